// [logic/lane_xbar_defines.svh]
// Purpose: Constants for the serial lane crossbar and inverter
// Assumes: Byte wide register port, printed byte offsets
// Notes:   Overview of operation below
//
// Overview of operation
// - Physical lane 4 carries the logical lane chosen by field bits [2:0].
// - Lane 4 selector resets to code 100, logical lane 4.
// - Physical lane 7 carries the logical lane chosen by bits [6:4] at 0x05B6.
// - Lane 7 selector resets to code 111, logical lane 7.
// - Physical lane 6 carries the logical lane chosen by bits [2:0] at 0x05B6.
// - Lane 6 selector resets to code 110, logical lane 6.
// - Lanes 0 to 3 use 3-bit selectors resetting to their own index.
`ifndef LANE_XBAR_DEFINES_SVH
`define LANE_XBAR_DEFINES_SVH

`define LANES        8
`define LANE_W       8
`define ADDR_W       16
`define SEL_W        3

// Register offsets
`define A_SEL_LO_A   16'h05B2
`define A_SEL_LO_B   16'h05B3
`define A_SEL_UP_A   16'h05B5
`define A_SEL_UP_B   16'h05B6
`define A_MAP_STAT   16'h05BD
`define A_INVERT     16'h05BF

// Field positions inside a selector register
`define F_SEL_EVEN_LSB 0
`define F_SEL_ODD_LSB  4

// Reset values
`define R_SEL_LO_A   8'h10
`define R_SEL_LO_B   8'h32
`define R_SEL_UP_A   8'h54
`define R_SEL_UP_B   8'h76
`define R_INVERT     8'h00

// Writable bits of a selector register
`define M_SEL        8'h77

`endif

// [logic/lane_xbar_pkg.sv]
// Purpose: Types for the serial lane crossbar and inverter
// Assumes: lane_xbar_defines.svh holds the numbers
// Notes:   Types only
`default_nettype none
`include "lane_xbar_defines.svh"
package lane_xbar_pkg;
  typedef logic [`LANE_W-1:0]          lane_word_t;
  typedef lane_word_t [`LANES-1:0]     lane_bus_t;
  typedef logic [`SEL_W-1:0]           sel_t;
  typedef sel_t [`LANES-1:0]           sel_bank_t;
endpackage : lane_xbar_pkg

`default_nettype wire

// [logic/serial_lane_crossbar_invert.sv]
// Purpose: Lane crossbar and per-lane polarity inversion
// Assumes: Lane words arrive synchronous to clk
// Notes:   Outputs registered, one cycle of latency
`timescale 1ns/100ps
`default_nettype none
`include "lane_xbar_defines.svh"

module serial_lane_crossbar_invert (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Register port
  input  wire logic [`ADDR_W-1:0]      regAddr,
  input  wire logic [7:0]              regWrData,
  input  wire logic                    regWrStrobe,
  input  wire logic                    regRdStrobe,
  output var  logic [7:0]              regRdData,
  // Logical lanes in
  input  wire lane_xbar_pkg::lane_bus_t logicalLaneIn,
  // Physical lanes out
  output var  lane_xbar_pkg::lane_bus_t serialOutLaneN
);

  // Selector and invert state
  lane_xbar_pkg::sel_bank_t selBank_reg;
  lane_xbar_pkg::sel_bank_t selBank_next;
  logic [`LANES-1:0]        invert_reg;
  logic [`LANES-1:0]        invert_next;
  logic [7:0]               rdData_reg;
  logic [7:0]               rdData_next;
  lane_xbar_pkg::lane_bus_t laneOut_reg;
  lane_xbar_pkg::lane_bus_t laneOut_next;
  logic [`LANES-1:0]        unrouted;

  assign regRdData      = rdData_reg;
  assign serialOutLaneN = laneOut_reg;

  // Logical lanes not used by any physical lane
  always_comb begin
    unrouted = '1;
    for (int p = 0; p < `LANES; p++) begin
      unrouted[selBank_reg[p]] = 1'b0;
    end
  end

  // Register writes and reads
  always_comb begin
    selBank_next = selBank_reg;
    invert_next  = invert_reg;
    rdData_next  = 8'h00;
    if (regWrStrobe) begin
      case (regAddr)
        `A_SEL_LO_A: begin
          selBank_next[0] = regWrData[`F_SEL_EVEN_LSB +: `SEL_W];
          selBank_next[1] = regWrData[`F_SEL_ODD_LSB +: `SEL_W];
        end
        `A_SEL_LO_B: begin
          selBank_next[2] = regWrData[`F_SEL_EVEN_LSB +: `SEL_W];
          selBank_next[3] = regWrData[`F_SEL_ODD_LSB +: `SEL_W];
        end
        `A_SEL_UP_A: begin
          selBank_next[4] = regWrData[`F_SEL_EVEN_LSB +: `SEL_W];
          selBank_next[5] = regWrData[`F_SEL_ODD_LSB +: `SEL_W];
        end
        `A_SEL_UP_B: begin
          selBank_next[6] = regWrData[`F_SEL_EVEN_LSB +: `SEL_W];
          selBank_next[7] = regWrData[`F_SEL_ODD_LSB +: `SEL_W];
        end
        `A_INVERT: begin
          invert_next = regWrData;
        end
        default: begin
          invert_next = invert_reg;
        end
      endcase
    end
    if (regRdStrobe) begin
      case (regAddr)
        `A_SEL_LO_A: begin
          rdData_next = {1'b0, selBank_reg[1], 1'b0, selBank_reg[0]};
        end
        `A_SEL_LO_B: begin
          rdData_next = {1'b0, selBank_reg[3], 1'b0, selBank_reg[2]};
        end
        `A_SEL_UP_A: begin
          rdData_next = {1'b0, selBank_reg[5], 1'b0, selBank_reg[4]};
        end
        `A_SEL_UP_B: begin
          rdData_next = {1'b0, selBank_reg[7], 1'b0, selBank_reg[6]};
        end
        `A_MAP_STAT: begin
          rdData_next = unrouted;
        end
        `A_INVERT: begin
          rdData_next = invert_reg;
        end
        default: begin
          rdData_next = 8'h00;
        end
      endcase
    end
  end

  // Crossbar then inversion
  always_comb begin
    laneOut_next = laneOut_reg;
    for (int p = 0; p < `LANES; p++) begin
      laneOut_next[p] = logicalLaneIn[selBank_reg[p]];
      if (invert_reg[p]) begin
        laneOut_next[p] = ~logicalLaneIn[selBank_reg[p]];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selBank_reg[0] <= 3'(`R_SEL_LO_A >> `F_SEL_EVEN_LSB);
      selBank_reg[1] <= 3'(`R_SEL_LO_A >> `F_SEL_ODD_LSB);
      selBank_reg[2] <= 3'(`R_SEL_LO_B >> `F_SEL_EVEN_LSB);
      selBank_reg[3] <= 3'(`R_SEL_LO_B >> `F_SEL_ODD_LSB);
      selBank_reg[4] <= 3'(`R_SEL_UP_A >> `F_SEL_EVEN_LSB);
      selBank_reg[5] <= 3'(`R_SEL_UP_A >> `F_SEL_ODD_LSB);
      selBank_reg[6] <= 3'(`R_SEL_UP_B >> `F_SEL_EVEN_LSB);
      selBank_reg[7] <= 3'(`R_SEL_UP_B >> `F_SEL_ODD_LSB);
      invert_reg     <= `R_INVERT;
      rdData_reg     <= 8'h00;
      laneOut_reg    <= '0;
    end else begin
      selBank_reg    <= selBank_next;
      invert_reg     <= invert_next;
      rdData_reg     <= rdData_next;
      laneOut_reg    <= laneOut_next;
    end
  end

  // Helper: no write seen since reset
  logic untouched_reg;
  logic untouched_next;
  always_comb begin
    untouched_next = untouched_reg;
    if (regWrStrobe) begin
      untouched_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      untouched_reg <= 1'b1;
    end else begin
      untouched_reg <= untouched_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wrUpA;
    regWrStrobe && (regAddr == `A_SEL_UP_A);
  endsequence

  sequence s_wrUpB;
    regWrStrobe && (regAddr == `A_SEL_UP_B);
  endsequence

  sequence s_wrInv;
    regWrStrobe && (regAddr == `A_INVERT);
  endsequence

  sequence s_wrLoA;
    regWrStrobe && (regAddr == `A_SEL_LO_A);
  endsequence

  sequence s_wrLoB;
    regWrStrobe && (regAddr == `A_SEL_LO_B);
  endsequence

  sequence s_rdInv;
    regRdStrobe && (regAddr == `A_INVERT);
  endsequence

  // No write, lane words steady over two edges
  sequence s_quiet;
    !regWrStrobe && $stable(logicalLaneIn) ##1 $stable(logicalLaneIn);
  endsequence

  a_lane4_route: assert property (
    s_wrUpA ##1 s_quiet |->
      serialOutLaneN[4] == (logicalLaneIn[$past(regWrData[2:0], 2)]
                            ^ {`LANE_W{invert_reg[4]}}))
    else $error("lane 4 route wrong");

  a_lane4_default: assert property (
    untouched_reg |-> selBank_reg[4] == 3'h4)
    else $error("lane 4 reset select wrong");

  a_lane7_route: assert property (
    s_wrUpB |=> selBank_reg[7] == $past(regWrData[6:4]))
    else $error("lane 7 select not written");

  a_lane7_default: assert property (
    untouched_reg |-> selBank_reg[7] == 3'h7)
    else $error("lane 7 reset select wrong");

  a_lane6_route: assert property (
    s_wrUpB |=> selBank_reg[6] == $past(regWrData[2:0]))
    else $error("lane 6 select not written");

  a_lane6_default: assert property (
    untouched_reg |-> selBank_reg[6] == 3'h6)
    else $error("lane 6 reset select wrong");

  a_invert_apply: assert property (
    s_wrInv ##1 s_quiet |->
      serialOutLaneN[7] == (logicalLaneIn[selBank_reg[7]]
                            ^ {`LANE_W{$past(regWrData[7], 2)}}))
    else $error("lane 7 polarity wrong");

  a_invert_default: assert property (
    untouched_reg |-> invert_reg == 8'h00)
    else $error("invert reset wrong");

  a_lower_default: assert property (
    untouched_reg |-> (selBank_reg[0] == 3'h0) && (selBank_reg[1] == 3'h1)
                   && (selBank_reg[2] == 3'h2) && (selBank_reg[3] == 3'h3))
    else $error("lower select reset wrong");

  a_reserved_zero: assert property (
    regRdStrobe && (regAddr[15:2] == 14'h016D) |=>
      (regRdData[7] == 1'b0) && (regRdData[3] == 1'b0))
    else $error("reserved bit read nonzero");

  a_other_kept: assert property (
    s_wrUpB |=> $stable(selBank_reg[5:0]))
    else $error("other selector disturbed");

  a_read_late: assert property (
    s_rdInv |=>
      regRdData == $past(invert_reg) ##1 (regRdData == 8'h00 || $past(regRdStrobe)))
    else $error("read data timing wrong");

  // Lane path after a selector write
  a_lane6_path: assert property (
    s_wrUpB ##1 s_quiet |->
      serialOutLaneN[6] == (logicalLaneIn[$past(regWrData[2:0], 2)]
                            ^ {`LANE_W{invert_reg[6]}}))
    else $error("lane 6 route wrong");

  a_lane7_path: assert property (
    s_wrUpB ##1 s_quiet |->
      serialOutLaneN[7] == (logicalLaneIn[$past(regWrData[6:4], 2)]
                            ^ {`LANE_W{invert_reg[7]}}))
    else $error("lane 7 route wrong");

  // Register field checks
  a_lane4_select: assert property (
    s_wrUpA |=> selBank_reg[4] == $past(regWrData[2:0]))
    else $error("lane 4 select not written");

  a_lower_a_write: assert property (
    s_wrLoA |=> (selBank_reg[0] == $past(regWrData[2:0]))
             && (selBank_reg[1] == $past(regWrData[6:4])))
    else $error("lanes 0 and 1 select not written");

  a_lower_b_write: assert property (
    s_wrLoB |=> (selBank_reg[2] == $past(regWrData[2:0]))
             && (selBank_reg[3] == $past(regWrData[6:4])))
    else $error("lanes 2 and 3 select not written");

  a_lower_kept: assert property (
    s_wrLoA |=> $stable(selBank_reg[7:2]))
    else $error("upper selectors disturbed");

  a_upper_a_kept: assert property (
    s_wrUpA |=> $stable(selBank_reg[7:6]) && $stable(selBank_reg[3:0]))
    else $error("neighbour selectors disturbed");

  a_invert_write: assert property (
    s_wrInv |=> invert_reg == $past(regWrData))
    else $error("polarity bits not written");

  a_invert_kept: assert property (
    regWrStrobe && (regAddr != `A_INVERT) |=> $stable(invert_reg))
    else $error("polarity bits disturbed");

  // Read port checks
  a_invert_readback: assert property (
    s_wrInv ##1 !regWrStrobe ##1 s_rdInv |=> regRdData == $past(regWrData, 3))
    else $error("polarity readback wrong");

  a_read_idle: assert property (
    !regRdStrobe |=> regRdData == 8'h00)
    else $error("read data not cleared");

  a_unmapped_zero: assert property (
    regRdStrobe && (regAddr == 16'h05B4) |=> regRdData == 8'h00)
    else $error("unmapped read nonzero");

  a_stat_identity: assert property (
    untouched_reg && regRdStrobe && (regAddr == `A_MAP_STAT) |=> regRdData == 8'h00)
    else $error("identity map reports unrouted lane");

endmodule : serial_lane_crossbar_invert

`default_nettype wire

// [tb/lane_receiver_model.sv]
// Purpose: Receiver side model capturing physical lane words
// Assumes: Receiver samples every rising clk edge
// Notes:   No link framing modelled, one cycle of capture latency
`timescale 1ns/100ps
`default_nettype none

module lane_receiver_model (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Physical lanes from device
  input  wire lane_xbar_pkg::lane_bus_t laneIn,
  // Captured words
  output var  lane_xbar_pkg::lane_bus_t laneWord
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      laneWord <= '0;
    end else begin
      laneWord <= laneIn;
    end
  end
endmodule : lane_receiver_model

`default_nettype wire

// [tb/serial_lane_crossbar_invert_test.sv]
// Purpose: Self-checking bench for lane crossbar and inverter
// Assumes: Read data one cycle after strobe
// Notes:   Lane words distinct per logical lane, one changed mid-run
`timescale 1ns/100ps
`default_nettype none
`include "lane_xbar_defines.svh"

module serial_lane_crossbar_invert_test;
  logic                     clk;
  logic                     rst;
  logic [`ADDR_W-1:0]       regAddr;
  logic [7:0]               regWrData;
  logic                     regWrStrobe;
  logic                     regRdStrobe;
  logic [7:0]               regRdData;
  lane_xbar_pkg::lane_bus_t laneIn;
  lane_xbar_pkg::lane_bus_t laneOut;
  lane_xbar_pkg::lane_bus_t rxLanes;
  lane_xbar_pkg::sel_bank_t selExp;
  logic [7:0]               invExp;
  int                       errTotal;
  int                       compares;

  serial_lane_crossbar_invert dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .logicalLaneIn(laneIn), .serialOutLaneN(laneOut));

  lane_receiver_model rx (.clk(clk), .rst(rst), .laneIn(laneOut), .laneWord(rxLanes));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task end_of_test;
    if (errTotal == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask : wr

  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask : rd

  // Output plus receiver capture latency
  task chkLanes;
    repeat (3) @(posedge clk);
    #1;
    for (int p = 0; p < 8; p++) begin
      check(rxLanes[p], laneIn[selExp[p]] ^ {8{invExp[p]}});
    end
  endtask : chkLanes

  initial begin
    rst         = 1'b1;
    regAddr     = '0;
    regWrData   = '0;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    invExp      = 8'h00;
    errTotal    = 0;
    compares    = 0;
    for (int l = 0; l < 8; l++) begin
      laneIn[l] = 8'(8'h11 * l + 8'h0A);
      selExp[l] = 3'(l);
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`A_SEL_LO_A, `R_SEL_LO_A);
    rd(`A_SEL_LO_B, `R_SEL_LO_B);
    rd(`A_SEL_UP_A, `R_SEL_UP_A);
    rd(`A_SEL_UP_B, `R_SEL_UP_B);
    rd(`A_INVERT, `R_INVERT);
    rd(16'h05B4, 8'h00);
    rd(`A_MAP_STAT, 8'h00);
    chkLanes;
    // Every code on lanes 7..4, reserved bits set
    for (int c = 0; c < 8; c++) begin
      wr(`A_SEL_UP_B, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
      wr(`A_SEL_UP_A, {1'b1, 3'(c + 1), 1'b1, 3'(c)});
      selExp[7] = 3'(c);
      selExp[6] = 3'(7 - c);
      selExp[5] = 3'(c + 1);
      selExp[4] = 3'(c);
      rd(`A_SEL_UP_B, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
      rd(`A_SEL_UP_A, {1'b0, 3'(c + 1), 1'b0, 3'(c)});
      chkLanes;
    end
    // Last code leaves logical lanes 4 to 6 unrouted
    rd(`A_MAP_STAT, 8'h70);
    wr(`A_INVERT, 8'hA0);
    invExp = 8'hA0;
    rd(`A_INVERT, 8'hA0);
    chkLanes;
    wr(`A_INVERT, 8'h5F);
    invExp = 8'h5F;
    chkLanes;
    // One edge through the crossbar, one in the receiver
    @(posedge clk);
    laneIn[3] <= 8'hE7;
    @(posedge clk);
    #1;
    check(rxLanes[3], 8'hC2);
    @(posedge clk);
    #1;
    check(rxLanes[3], 8'h18);
    // Lower lanes reversed, upper lanes kept
    wr(`A_SEL_LO_A, 8'h23);
    wr(`A_SEL_LO_B, 8'h01);
    selExp[0] = 3'h3;
    selExp[1] = 3'h2;
    selExp[2] = 3'h1;
    selExp[3] = 3'h0;
    rd(`A_SEL_LO_A, 8'h23);
    rd(`A_SEL_LO_B, 8'h01);
    rd(`A_SEL_UP_B, 8'h70);
    chkLanes;
    // Reset in mid-run restores the identity map
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    invExp = 8'h00;
    for (int l = 0; l < 8; l++) begin
      selExp[l] = 3'(l);
    end
    rd(`A_SEL_UP_B, `R_SEL_UP_B);
    rd(`A_SEL_UP_A, `R_SEL_UP_A);
    rd(`A_SEL_LO_A, `R_SEL_LO_A);
    rd(`A_INVERT, `R_INVERT);
    chkLanes;
    end_of_test;
  end

  initial begin
    #20000;
    errTotal++;
    end_of_test;
  end
endmodule : serial_lane_crossbar_invert_test

`default_nettype wire
